// ---- src/wot_consts.vh ----
// constants for the wait one-shot pulse timer
`ifndef WOT_CONSTS_VH
`define WOT_CONSTS_VH
// register byte offsets
`define WOT_OFF_TIMER_CTRL   8'h00
`define WOT_OFF_ONESHOT_CTRL 8'h04
`define WOT_OFF_PIN_CTRL     8'h08
`define WOT_OFF_SOURCE_SEL   8'h0c
`define WOT_OFF_PRESCALER    8'h10
`define WOT_OFF_SECONDARY    8'h14
`define WOT_OFF_PRIMARY      8'h18
// timer control fields
`define WOT_BIT_START        0
`define WOT_BIT_STATUS       1
`define WOT_BIT_FSTOP        2
// one-shot control fields
`define WOT_BIT_OS_START     0
`define WOT_BIT_OS_STOP      1
`define WOT_BIT_OS_ACTIVE    2
// pin control fields
`define WOT_BIT_LEVEL        0
`define WOT_BIT_TRIG_EN      1
`define WOT_BIT_TRIG_EDGE    2
// count source codes
`define WOT_SRC_DIV1         2'h0
`define WOT_SRC_DIV2         2'h1
`define WOT_SRC_DIV8         2'h2
`define WOT_SRC_NEIGHBOUR    2'h3
// reset values
`define WOT_RST_PRESCALER    8'hff
`define WOT_RST_SECONDARY    8'hff
`define WOT_RST_PRIMARY      8'hff
// sync delay in count-source cycles before flags settle
`define WOT_SYNC_TICKS       2'h2
`endif

// ---- src/wot_count_src.v ----
// count source selector: full clock, /2, /8 or neighbour underflow
`timescale 1ns/10ps
`include "wot_consts.vh"
module wot_count_src (
    aclk,
    aresetn,
    ce,
    sel,
    neighbour_uf,
    tick
);
    input  wire       aclk;
    input  wire       aresetn;
    input  wire       ce;
    input  wire [1:0] sel;
    input  wire       neighbour_uf;
    output reg        tick;

    reg [2:0] div_q;

    // ----------------------------------------
    // free divider and tick select
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 3'h0;
            tick  <= 1'b0;
        end else if (ce) begin
            div_q <= div_q + 3'h1;
            case (sel)
                `WOT_SRC_DIV1:      tick <= 1'b1;
                `WOT_SRC_DIV2:      tick <= (div_q[0] == 1'b1);
                `WOT_SRC_DIV8:      tick <= (div_q == 3'h7);
                default:            tick <= neighbour_uf;
            endcase
        end
    end
endmodule

// ---- src/wot_timer.v ----
// wait one-shot pulse timer with axi4-lite registers
// What this block does
// - counter runs from selected source: clock, /2, /8, neighbour underflow
// - wait phase decrements primary; underflow loads secondary, pulse phase follows
// - secondary underflow reloads primary, ends count, clears active flag
// - wait lasts (n+1)(m+1) source periods via prescaler and primary
// - pulse lasts (n+1)(p+1) source periods
// - runs only after start bit is set and a later trigger comes
// - trigger is a software one-shot start write or an external pin edge
// - pin triggers only while the pin trigger enable bit is 1
// - count stops after final reload or at once on forced stop
// - clearing start or one-shot stop reloads counter then stops
// - interrupt raised one clock after secondary underflow, at pulse end
// - pulse pin carries waveform, active level from level select bit
// - count readable via primary and prescaler registers, bytewise
// - prescaler or primary writes while stopped load both reload and counter
// - writes while counting load reload only, used when that counter next reloads
// - stopped after reset; software loads values before starting
// - status stays 0 for 1-2 source cycles after start set
// - status stays 1 for 1-2 source cycles after start cleared
// - active flag rises 1-2 source cycles after trigger; wait begins
// - trigger while active does not restart
`timescale 1ns/10ps
`include "wot_consts.vh"
module wot_timer (
    aclk,
    aresetn,
    ce,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    external_trigger_pin,
    neighbour_underflow,
    pulse_output_pin,
    timer_irq
);
    input  wire        aclk;
    input  wire        aresetn;
    input  wire        ce;
    input  wire [7:0]  s_axi_awaddr;
    input  wire        s_axi_awvalid;
    output reg         s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output reg         s_axi_wready;
    output reg  [1:0]  s_axi_bresp;
    output reg         s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [7:0]  s_axi_araddr;
    input  wire        s_axi_arvalid;
    output reg         s_axi_arready;
    output reg  [31:0] s_axi_rdata;
    output reg  [1:0]  s_axi_rresp;
    output reg         s_axi_rvalid;
    input  wire        s_axi_rready;
    input  wire        external_trigger_pin;
    input  wire        neighbour_underflow;
    output reg         pulse_output_pin;
    output reg         timer_irq;

    // phase codes
    localparam PH_IDLE  = 2'h0;
    localparam PH_WAIT  = 2'h1;
    localparam PH_PULSE = 2'h2;

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg       start_q;
    reg       status_q;
    reg       active_q;
    reg       level_q;
    reg       trig_en_q;
    reg       trig_edge_q;
    reg [1:0] src_q;
    reg [7:0] pre_rl_q;
    reg [7:0] sec_rl_q;
    reg [7:0] pri_rl_q;
    reg [7:0] pre_cnt_q;
    reg [7:0] main_cnt_q;
    reg [1:0] phase_q;
    reg [1:0] st_sync_q;
    reg [1:0] os_sync_q;
    reg       os_pend_q;
    reg       stop_pend_q;
    reg       pin_q;
    reg       half_q;
    reg [7:0] aw_addr_q;
    reg       aw_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg       w_have_q;

    wire tick;
    wot_count_src u_src (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .ce           (ce),
        .sel          (src_q),
        .neighbour_uf (neighbour_underflow),
        .tick         (tick)
    );

    // word address match for both decoders
    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a[7:2] == off[7:2]);
        end
    endfunction

    // write commit when both halves are held
    wire       wr_go   = aw_have_q && w_have_q && !s_axi_bvalid;
    wire       wr_lane = w_strb_q[0];
    wire [7:0] wd      = w_data_q[7:0];
    wire       wr_tc   = wr_go && wr_lane && hit(aw_addr_q, `WOT_OFF_TIMER_CTRL);
    wire       wr_oc   = wr_go && wr_lane && hit(aw_addr_q, `WOT_OFF_ONESHOT_CTRL);
    wire       wr_pre  = wr_go && wr_lane && hit(aw_addr_q, `WOT_OFF_PRESCALER);
    wire       wr_sec  = wr_go && wr_lane && hit(aw_addr_q, `WOT_OFF_SECONDARY);
    wire       wr_pri  = wr_go && wr_lane && hit(aw_addr_q, `WOT_OFF_PRIMARY);
    wire       mapped  = (aw_addr_q <= (`WOT_OFF_PRIMARY | 8'h03));

    // pin edge detect; pin is synchronous to aclk
    reg  ext_q;
    wire ext_edge = trig_edge_q ? (ext_q && !external_trigger_pin)
                                : (!ext_q && external_trigger_pin);
    wire pin_trig = trig_en_q && ext_edge;
    wire sw_trig  = wr_oc && wd[`WOT_BIT_OS_START];
    wire sw_stop  = wr_oc && wd[`WOT_BIT_OS_STOP];
    wire fstop    = wr_tc && wd[`WOT_BIT_FSTOP];

    // prescaler and main underflow
    wire pre_uf  = tick && (pre_cnt_q == 8'h00);
    wire main_uf = pre_uf && (main_cnt_q == 8'h00);
    wire run     = status_q && active_q && (phase_q != PH_IDLE);

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else if (ce) begin
            // one-cycle ready pulses: accept each half once
            s_axi_awready <= !aw_have_q && s_axi_awvalid && !s_axi_awready;
            s_axi_wready  <= !w_have_q && s_axi_wvalid && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped ? 2'h0 : 2'h3;   // decerr on holes
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else if (ce) begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                s_axi_rdata  <= 32'h0;
                if (hit(s_axi_araddr, `WOT_OFF_TIMER_CTRL))
                    s_axi_rdata[2:0] <= {1'b0, status_q, start_q};
                else if (hit(s_axi_araddr, `WOT_OFF_ONESHOT_CTRL))
                    s_axi_rdata[2:0] <= {active_q, 2'b00};
                else if (hit(s_axi_araddr, `WOT_OFF_PIN_CTRL))
                    s_axi_rdata[2:0] <= {trig_edge_q, trig_en_q, level_q};
                else if (hit(s_axi_araddr, `WOT_OFF_SOURCE_SEL))
                    s_axi_rdata[1:0] <= src_q;
                else if (hit(s_axi_araddr, `WOT_OFF_PRESCALER))
                    s_axi_rdata[7:0] <= pre_cnt_q;
                else if (hit(s_axi_araddr, `WOT_OFF_SECONDARY))
                    s_axi_rdata[7:0] <= sec_rl_q;
                else if (hit(s_axi_araddr, `WOT_OFF_PRIMARY))
                    s_axi_rdata[7:0] <= main_cnt_q;
                else
                    s_axi_rresp <= 2'h3;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // control registers and reload values
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            start_q     <= 1'b0;
            level_q     <= 1'b0;
            trig_en_q   <= 1'b0;
            trig_edge_q <= 1'b0;
            src_q       <= `WOT_SRC_DIV1;
            pre_rl_q    <= `WOT_RST_PRESCALER;
            sec_rl_q    <= `WOT_RST_SECONDARY;
            pri_rl_q    <= `WOT_RST_PRIMARY;
            ext_q       <= 1'b0;
        end else if (ce) begin
            ext_q <= external_trigger_pin;
            if (wr_tc)
                start_q <= wd[`WOT_BIT_START] && !wd[`WOT_BIT_FSTOP];
            if (wr_go && wr_lane && hit(aw_addr_q, `WOT_OFF_PIN_CTRL)) begin
                level_q     <= wd[`WOT_BIT_LEVEL];
                trig_en_q   <= wd[`WOT_BIT_TRIG_EN];
                trig_edge_q <= wd[`WOT_BIT_TRIG_EDGE];
            end
            if (wr_go && wr_lane && hit(aw_addr_q, `WOT_OFF_SOURCE_SEL))
                src_q <= wd[1:0];
            // reload values always take writes
            if (wr_pre) pre_rl_q <= wd;
            if (wr_sec) sec_rl_q <= wd;
            if (wr_pri) pri_rl_q <= wd;
        end
    end

    // ----------------------------------------
    // status and one-shot synchronisers, counter
    // ----------------------------------------
    // flags settle after two source ticks, giving the 1..2 cycle window
    always @(posedge aclk) begin
        if (!aresetn) begin
            status_q    <= 1'b0;
            st_sync_q   <= 2'h0;
            active_q    <= 1'b0;
            os_sync_q   <= 2'h0;
            os_pend_q   <= 1'b0;
            stop_pend_q <= 1'b0;
            phase_q     <= PH_IDLE;
            pre_cnt_q   <= `WOT_RST_PRESCALER;
            main_cnt_q  <= `WOT_RST_PRIMARY;
            pin_q       <= 1'b0;
            half_q      <= 1'b0;
        end else if (ce) begin
            // start bit to status flag
            if (fstop) begin
                status_q  <= 1'b0;
                st_sync_q <= 2'h0;
            end else if (start_q != status_q) begin
                if (tick)
                    st_sync_q <= st_sync_q + 2'h1;
                if (tick && st_sync_q == `WOT_SYNC_TICKS - 2'h1) begin
                    status_q  <= start_q;
                    st_sync_q <= 2'h0;
                end
            end else begin
                st_sync_q <= 2'h0;
            end
            // trigger capture, ignored while active
            if ((sw_trig || pin_trig) && status_q && !active_q)
                os_pend_q <= 1'b1;
            if (sw_stop && active_q)
                stop_pend_q <= 1'b1;
            if (os_pend_q || stop_pend_q) begin
                if (tick)
                    os_sync_q <= os_sync_q + 2'h1;
                if (tick && os_sync_q == `WOT_SYNC_TICKS - 2'h1) begin
                    os_sync_q <= 2'h0;
                    if (stop_pend_q) begin
                        stop_pend_q <= 1'b0;
                        os_pend_q   <= 1'b0;
                        active_q    <= 1'b0;
                        phase_q     <= PH_IDLE;
                        pre_cnt_q   <= pre_rl_q;
                        main_cnt_q  <= pri_rl_q;
                    end else begin
                        os_pend_q  <= 1'b0;
                        active_q   <= 1'b1;
                        phase_q    <= PH_WAIT;
                        pre_cnt_q  <= pre_rl_q;
                        main_cnt_q <= pri_rl_q;
                    end
                end
            end
            // irq and pulse end both trail the final underflow by one clock
            half_q <= 1'b0;
            if (run && tick) begin
                pre_cnt_q <= pre_uf ? pre_rl_q : pre_cnt_q - 8'h01;
                if (pre_uf)
                    main_cnt_q <= main_cnt_q - 8'h01;
                if (main_uf && phase_q == PH_WAIT) begin
                    phase_q    <= PH_PULSE;
                    main_cnt_q <= sec_rl_q;
                    pin_q      <= 1'b1;
                end else if (main_uf) begin
                    phase_q    <= PH_IDLE;
                    main_cnt_q <= pri_rl_q;
                    active_q   <= 1'b0;
                    pin_q      <= 1'b0;
                    half_q     <= 1'b1;
                end
            end
            // start cleared or forced stop: reload and halt
            if ((fstop || (!status_q && !start_q)) && phase_q != PH_IDLE) begin
                phase_q    <= PH_IDLE;
                active_q   <= 1'b0;
                pin_q      <= 1'b0;
                pre_cnt_q  <= pre_rl_q;
                main_cnt_q <= pri_rl_q;
            end
            // prescaler and primary writes while stopped also load the counter
            if (!status_q && phase_q == PH_IDLE) begin
                if (wr_pre) pre_cnt_q  <= wd;
                if (wr_pri) main_cnt_q <= wd;
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            pulse_output_pin <= 1'b0;
            timer_irq        <= 1'b0;
        end else if (ce) begin
            pulse_output_pin <= pin_q ^ level_q;
            timer_irq        <= half_q;
        end
    end
endmodule

// ---- dv/wot_timer_properties.sv ----
// port-level assertions for the wait one-shot pulse timer
`timescale 1ns/10ps
module wot_timer_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        pulse_output_pin,
    input wire logic        timer_irq
);
    // --------------------
    // one clock domain, reset disables everything
    // --------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_reset_quiet;
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !timer_irq && !pulse_output_pin;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    property p_irq_single;
        timer_irq && ce |=> !timer_irq;
    endproperty
    a_irq_single: assert property (p_irq_single) else $error("irq longer than one cycle");
    // irq sits on the pulse's closing edge, one clock of slack
    property p_irq_at_end;
        timer_irq |-> (pulse_output_pin != $past(pulse_output_pin))
            || ($past(pulse_output_pin) != $past(pulse_output_pin, 2));
    endproperty
    a_irq_at_end: assert property (p_irq_at_end) else $error("irq away from pulse end");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_ar_answer;
        s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid;
    endproperty
    a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
    property p_aw_answer;
        s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_aw_answer: assert property (p_aw_answer) else $error("write answer late");
    // upper bytes read zero; codes okay or decerr
    property p_r_upper;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && (s_axi_rresp == 2'h0 || s_axi_rresp == 2'h3);
    endproperty
    a_r_upper: assert property (p_r_upper) else $error("bad read data or code");
endmodule

bind wot_timer wot_timer_props i_props (
    .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pulse_output_pin, .timer_irq
);

// ---- dv/wot_far_end.sv ----
// far-side model: external trigger edge source and neighbour underflow
`timescale 1ns/10ps
module wot_far_end #(
    parameter int NB_PERIOD = 5
) (
    input  wire logic aclk,
    input  wire logic fire,
    output logic      external_trigger_pin = 1'b0,
    output logic      neighbour_underflow = 1'b0
);
    int nb_cnt = 0, hold = 0;
    // neighbour underflow every NB_PERIOD clocks
    always @(posedge aclk) begin
        nb_cnt <= (nb_cnt == NB_PERIOD - 1) ? 0 : nb_cnt + 1;
        neighbour_underflow <= (nb_cnt == NB_PERIOD - 1);
    end
    // fire gives one rising edge, held a few clocks
    always @(posedge aclk) begin
        if (fire)
            hold <= 4;
        else if (hold > 0)
            hold <= hold - 1;
        external_trigger_pin <= fire || hold > 1;
    end
endmodule

// ---- dv/wait_oneshot_pulse_timer_tb.sv ----
// self-checking bench for the wait one-shot pulse timer
`timescale 1ns/10ps
`include "wot_consts.vh"
module wait_oneshot_pulse_timer_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid, trig_pin, nb_uf, pulse_pin, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    logic        fire = 1'b0, act = 1'b1, prev_pin = 1'b0;
    logic [31:0] rd_v;
    logic [1:0]  resp_v;
    int          bad_count = 0, tests_run = 0, cyc = 0, rise_cyc = 0, width = 0, shots = 0, irqs = 0;
    int          divs[4] = '{1, 2, 8, 5};

    wot_timer i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .external_trigger_pin(trig_pin), .neighbour_underflow(nb_uf),
        .pulse_output_pin(pulse_pin), .timer_irq(irq));
    wot_far_end #(.NB_PERIOD(5)) i_far (.aclk(aclk), .fire(fire),
        .external_trigger_pin(trig_pin), .neighbour_underflow(nb_uf));

    always #25 aclk = ~aclk;
    // pulse monitor; act is the pin's active level
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        prev_pin <= pulse_pin;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (pulse_pin === act && prev_pin !== act) rise_cyc <= cyc;
        if (pulse_pin !== act && prev_pin === act && aresetn) begin
            width <= cyc - rise_cyc;
            shots <= shots + 1;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one register write (wr=1) or read
    task automatic axi(input bit wr, input logic [7:0] a, input logic [7:0] d);
        bit done = 0;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= {24'h0, d};
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        for (int i = 0; i < 60 && !done; i++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (arready === 1'b1) arvalid <= 1'b0;
            if ((wr ? bvalid : rvalid) === 1'b1) begin
                done = 1;
                bready <= 1'b0;
                rready <= 1'b0;
                resp_v = wr ? bresp : rresp;
                rd_v = rdata;
            end
        end
        if (!done) check(32'h0, 32'h1);
        if (!done) test_done;
    endtask
    task automatic wait_shot(input int limit, output bit seen);
        int s0 = shots;
        seen = 0;
        for (int i = 0; i < limit && !seen; i++) begin
            @(posedge aclk);
            seen = (shots != s0);
        end
    endtask
    // only the status field is touched while it settles
    task automatic wait_status(input logic exp);
        for (int i = 0; i < 20; i++) begin
            axi(0, `WOT_OFF_TIMER_CTRL, 8'h00);
            if (rd_v[`WOT_BIT_STATUS] === exp) break;
        end
        check(rd_v[`WOT_BIT_STATUS], exp);
    endtask
    task automatic t_reset;
        for (int k = 0; k < 3; k++) begin
            axi(0, `WOT_OFF_PRESCALER + 8'(4 * k), 8'h00);
            check(rd_v, 32'hff);
        end
        axi(0, `WOT_OFF_TIMER_CTRL, 8'h00);
        check(rd_v[`WOT_BIT_STATUS], 1'b0);
        axi(0, 8'h40, 8'h00);
        check(resp_v, 2'h3);
        axi(1, 8'h44, 8'h5a);
        check(resp_v, 2'h3);
    endtask
    // slow /8 source makes the status delay visible
    task automatic t_status;
        bit seen;
        axi(1, `WOT_OFF_SOURCE_SEL, 8'h02);
        axi(1, `WOT_OFF_TIMER_CTRL, 8'h01);
        axi(0, `WOT_OFF_TIMER_CTRL, 8'h00);
        check(rd_v[`WOT_BIT_STATUS], 1'b0);
        wait_status(1'b1);
        axi(1, `WOT_OFF_TIMER_CTRL, 8'h00);
        axi(0, `WOT_OFF_TIMER_CTRL, 8'h00);
        check(rd_v[`WOT_BIT_STATUS], 1'b1);
        wait_status(1'b0);
        axi(1, `WOT_OFF_ONESHOT_CTRL, 8'h01);
        wait_shot(200, seen);
        check(seen, 1'b0);
    endtask
    // prescaler and primary never both zero here
    task automatic t_shot(input logic [1:0] src, input int div, input logic [7:0] n, p, m);
        int t0;
        int i0 = irqs;
        bit seen;
        axi(1, `WOT_OFF_SOURCE_SEL, {6'h0, src});
        axi(1, `WOT_OFF_PRESCALER, n);
        axi(1, `WOT_OFF_SECONDARY, p);
        axi(1, `WOT_OFF_PRIMARY, m);
        axi(0, `WOT_OFF_PRIMARY, 8'h00);
        check(rd_v, {24'h0, m});
        axi(1, `WOT_OFF_TIMER_CTRL, 8'h01);
        wait_status(1'b1);
        t0 = cyc;
        axi(1, `WOT_OFF_ONESHOT_CTRL, 8'h01);
        wait_shot(4000, seen);
        check(seen, 1'b1);
        check(width, (n + 1) * (p + 1) * div);
        check(rise_cyc - t0 >= (n + 1) * (m + 1) * div, 1'b1);
        check(rise_cyc - t0 <= ((n + 1) * (m + 1) + 4) * div + 12, 1'b1);
        repeat (4) @(posedge aclk);
        check(irqs - i0, 1);
        axi(0, `WOT_OFF_ONESHOT_CTRL, 8'h00);
        check(rd_v[`WOT_BIT_OS_ACTIVE], 1'b0);
        axi(0, `WOT_OFF_PRIMARY, 8'h00);
        check(rd_v, {24'h0, m});
        axi(1, `WOT_OFF_TIMER_CTRL, 8'h00);
        wait_status(1'b0);
    endtask
    task automatic t_pin;
        bit seen;
        axi(1, `WOT_OFF_PIN_CTRL, 8'h01);
        repeat (2) @(posedge aclk);
        act = 1'b0;
        axi(1, `WOT_OFF_SOURCE_SEL, 8'h00);
        axi(1, `WOT_OFF_TIMER_CTRL, 8'h01);
        wait_status(1'b1);
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        wait_shot(200, seen);
        check(seen, 1'b0);
        check(pulse_pin, 1'b1);
        axi(1, `WOT_OFF_PIN_CTRL, 8'h07);
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        wait_shot(200, seen);
        check(seen, 1'b1);
        check(width, 32'd6);
        axi(1, `WOT_OFF_PIN_CTRL, 8'h00);
        repeat (2) @(posedge aclk);
        act = 1'b1;
    endtask
    // 20-clock pulse; new secondary and retrigger land inside it
    task automatic t_retrig;
        bit seen;
        axi(1, `WOT_OFF_TIMER_CTRL, 8'h00);
        wait_status(1'b0);
        axi(1, `WOT_OFF_SECONDARY, 8'h09);
        axi(1, `WOT_OFF_TIMER_CTRL, 8'h01);
        wait_status(1'b1);
        axi(1, `WOT_OFF_ONESHOT_CTRL, 8'h01);
        for (int i = 0; i < 100 && pulse_pin !== act; i++) @(posedge aclk);
        axi(1, `WOT_OFF_SECONDARY, 8'h01);
        axi(1, `WOT_OFF_ONESHOT_CTRL, 8'h01);
        wait_shot(100, seen);
        check(width, 32'd20);
        wait_shot(100, seen);
        check(seen, 1'b0);
        axi(1, `WOT_OFF_ONESHOT_CTRL, 8'h01);
        wait_shot(100, seen);
        check(width, 32'd4);
    endtask
    // stop in the wait phase: first by one-shot stop, then forced
    task automatic t_stops;
        bit seen;
        int i0;
        axi(1, `WOT_OFF_TIMER_CTRL, 8'h00);
        wait_status(1'b0);
        axi(1, `WOT_OFF_PRIMARY, 8'hc8);
        axi(1, `WOT_OFF_TIMER_CTRL, 8'h01);
        wait_status(1'b1);
        i0 = irqs;
        axi(1, `WOT_OFF_ONESHOT_CTRL, 8'h01);
        repeat (30) @(posedge aclk);
        axi(1, `WOT_OFF_ONESHOT_CTRL, 8'h02);
        wait_shot(600, seen);
        check(seen, 1'b0);
        axi(0, `WOT_OFF_PRIMARY, 8'h00);
        check(rd_v, 32'hc8);
        axi(1, `WOT_OFF_ONESHOT_CTRL, 8'h01);
        axi(1, `WOT_OFF_TIMER_CTRL, 8'h05);
        wait_shot(600, seen);
        check(seen, 1'b0);
        check(irqs - i0, 0);
    endtask
    task automatic test_done;
        $display("checks run %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_status;
        for (int s = 0; s < 4; s++) t_shot(2'(s), divs[s], 8'h01, 8'h02, 8'h03);
        t_pin;
        t_retrig;
        t_stops;
        test_done;
    end
    // watchdog: the run needs a few thousand clocks
    initial begin
        repeat (40000) @(posedge aclk);
        bad_count++;
        test_done;
    end
endmodule
